/* File: verilog/tzc_pkg.sv */
// Constants shared by the thermal and temperature-zone control register bank
package tzc_pkg;

  // Register offsets on the host register port
  localparam logic [7:0] TEMP_CTRL_ADDR = 8'h16;
  localparam logic [7:0] ZONE_CTRL_ADDR = 8'h17;

  // Values after power-on or register reset
  localparam logic [7:0] TEMP_CTRL_RST = 8'hc0;
  localparam logic [7:0] ZONE_CTRL_RST = 8'h7a;

  // Bits of the temperature control register that survive watchdog expiry
  localparam logic [7:0] TEMP_CTRL_WD_KEEP = 8'h0f;

  // Read value for offsets that hold no register
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  // Field positions, temperature control register
  localparam int DIE_REG_LSB = 6;
  localparam int DIE_SHUT_LSB = 4;
  localparam int BUS_PD_BIT = 3;
  localparam int FIRST_PD_BIT = 2;
  localparam int SECOND_PD_BIT = 1;
  localparam int BKUP_FET_BIT = 0;

  // Field positions, temperature-zone control register
  localparam int WARM_V_LSB = 5;
  localparam int WARM_I_LSB = 3;
  localparam int COOL_I_LSB = 1;
  localparam int ZONE_RSVD_BIT = 0;

  // Die regulation thresholds, degrees C, codes 0 to 3
  localparam logic [7:0] DIE_REG_C0 = 8'h3c;
  localparam logic [7:0] DIE_REG_C1 = 8'h50;
  localparam logic [7:0] DIE_REG_C2 = 8'h64;
  localparam logic [7:0] DIE_REG_C3 = 8'h78;

  // Die shutdown thresholds, degrees C, codes 0 to 3
  localparam logic [7:0] DIE_SHUT_C0 = 8'h96;
  localparam logic [7:0] DIE_SHUT_C1 = 8'h82;
  localparam logic [7:0] DIE_SHUT_C2 = 8'h78;
  localparam logic [7:0] DIE_SHUT_C3 = 8'h55;

  // Warm-zone charge voltage reduction, mV, codes 1 to 6
  localparam logic [9:0] WARM_DROP_1 = 10'h320;
  localparam logic [9:0] WARM_DROP_2 = 10'h258;
  localparam logic [9:0] WARM_DROP_3 = 10'h190;
  localparam logic [9:0] WARM_DROP_4 = 10'h12c;
  localparam logic [9:0] WARM_DROP_5 = 10'h0c8;
  localparam logic [9:0] WARM_DROP_6 = 10'h064;
  localparam logic [9:0] WARM_DROP_NONE = 10'h000;

  // Charge current scale, percent of the programmed target
  localparam logic [6:0] PCT_SUSPEND = 7'h00;
  localparam logic [6:0] PCT_20 = 7'h14;
  localparam logic [6:0] PCT_40 = 7'h28;
  localparam logic [6:0] PCT_FULL = 7'h64;

endpackage : tzc_pkg

/* File: verilog/tzc_setting_decode.sv */
// Registered decode of the control fields into thresholds and charge scaling
`timescale 1ns/1ps

module tzc_setting_decode (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [1:0] die_regulation_threshold,
  input wire logic [1:0] die_shutdown_threshold,
  input wire logic [2:0] warm_zone_voltage_setting,
  input wire logic [1:0] warm_zone_current_setting,
  input wire logic [1:0] cool_zone_current_setting,
  output logic [7:0] die_reg_temp_ff,
  output logic [7:0] die_shut_temp_ff,
  output logic [9:0] warm_voltage_drop_ff,
  output logic warm_voltage_suspend_ff,
  output logic [6:0] warm_current_pct_ff,
  output logic [6:0] cool_current_pct_ff
);

  logic [7:0] nxt_die_reg_temp;
  logic [7:0] nxt_die_shut_temp;
  logic [9:0] nxt_warm_voltage_drop;
  logic nxt_warm_voltage_suspend;
  logic [6:0] nxt_warm_current_pct;
  logic [6:0] nxt_cool_current_pct;

  //////////////////////////////////////////////////////////////////////////////
  // Die thresholds
  always_comb begin
    case (die_regulation_threshold)
      2'h0: nxt_die_reg_temp = tzc_pkg::DIE_REG_C0;
      2'h1: nxt_die_reg_temp = tzc_pkg::DIE_REG_C1;
      2'h2: nxt_die_reg_temp = tzc_pkg::DIE_REG_C2;
      default: nxt_die_reg_temp = tzc_pkg::DIE_REG_C3;
    endcase
    case (die_shutdown_threshold)
      2'h0: nxt_die_shut_temp = tzc_pkg::DIE_SHUT_C0;
      2'h1: nxt_die_shut_temp = tzc_pkg::DIE_SHUT_C1;
      2'h2: nxt_die_shut_temp = tzc_pkg::DIE_SHUT_C2;
      default: nxt_die_shut_temp = tzc_pkg::DIE_SHUT_C3;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Temperature-zone charge adjustments
  always_comb begin
    nxt_warm_voltage_suspend = 1'b0;
    case (warm_zone_voltage_setting)
      3'h0: begin
        nxt_warm_voltage_drop = tzc_pkg::WARM_DROP_NONE;
        nxt_warm_voltage_suspend = 1'b1;
      end
      3'h1: nxt_warm_voltage_drop = tzc_pkg::WARM_DROP_1;
      3'h2: nxt_warm_voltage_drop = tzc_pkg::WARM_DROP_2;
      3'h3: nxt_warm_voltage_drop = tzc_pkg::WARM_DROP_3;
      3'h4: nxt_warm_voltage_drop = tzc_pkg::WARM_DROP_4;
      3'h5: nxt_warm_voltage_drop = tzc_pkg::WARM_DROP_5;
      3'h6: nxt_warm_voltage_drop = tzc_pkg::WARM_DROP_6;
      default: nxt_warm_voltage_drop = tzc_pkg::WARM_DROP_NONE;
    endcase
    // warm current scale, unlisted code 0 treated as suspend
    case (warm_zone_current_setting)
      2'h0: nxt_warm_current_pct = tzc_pkg::PCT_SUSPEND;
      2'h1: nxt_warm_current_pct = tzc_pkg::PCT_20;
      2'h2: nxt_warm_current_pct = tzc_pkg::PCT_40;
      default: nxt_warm_current_pct = tzc_pkg::PCT_FULL;
    endcase
    case (cool_zone_current_setting)
      2'h0: nxt_cool_current_pct = tzc_pkg::PCT_SUSPEND;
      2'h1: nxt_cool_current_pct = tzc_pkg::PCT_20;
      2'h2: nxt_cool_current_pct = tzc_pkg::PCT_40;
      default: nxt_cool_current_pct = tzc_pkg::PCT_FULL;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output registers, reset to the decode of the default codes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      die_reg_temp_ff <= tzc_pkg::DIE_REG_C3;
      die_shut_temp_ff <= tzc_pkg::DIE_SHUT_C0;
      warm_voltage_drop_ff <= tzc_pkg::WARM_DROP_3;
      warm_voltage_suspend_ff <= 1'b0;
      warm_current_pct_ff <= tzc_pkg::PCT_FULL;
      cool_current_pct_ff <= tzc_pkg::PCT_20;
    end else begin
      die_reg_temp_ff <= nxt_die_reg_temp;
      die_shut_temp_ff <= nxt_die_shut_temp;
      warm_voltage_drop_ff <= nxt_warm_voltage_drop;
      warm_voltage_suspend_ff <= nxt_warm_voltage_suspend;
      warm_current_pct_ff <= nxt_warm_current_pct;
      cool_current_pct_ff <= nxt_cool_current_pct;
    end
  end

endmodule : tzc_setting_decode

/* File: verilog/tzc_regs.sv */
// Thermal and temperature-zone control register bank with its host port
`timescale 1ns/1ps

// Functional notes
// - Temperature control register resets to C0h
// - Zone register resets 7Ah, bit0 reads zero
// - Bit 3 enables bus pull-down, register reset
// - Bit 2 enables first sense pull-down
// - Bit 1 enables second sense pull-down
// - Warm voltage code: suspend, reductions, unchanged
// - Warm current code scales 20, 40, 100%
// - Cool current code: suspend, 20, 40, 100%
module tzc_regs (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic reg_reset,
  input wire logic watchdog_expire,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic host_rd,
  output logic [7:0] host_rdata_ff,
  output logic host_rvalid_ff,
  output logic [7:0] temperature_control_ff,
  output logic [7:0] temp_zone_charge_control_ff,
  output logic bus_input_pulldown_enable,
  output logic first_sense_pulldown_enable,
  output logic second_sense_pulldown_enable,
  output logic backup_input_fet_on,
  output logic [7:0] die_reg_temp_ff,
  output logic [7:0] die_shut_temp_ff,
  output logic [9:0] warm_voltage_drop_ff,
  output logic warm_voltage_suspend_ff,
  output logic [6:0] warm_current_pct_ff,
  output logic [6:0] cool_current_pct_ff
);

  logic temp_hit;
  logic zone_hit;
  logic temp_write;
  logic zone_write;
  logic [1:0] die_reg_code_ff;
  logic [1:0] die_shut_code_ff;
  logic [3:0] temp_low_bits;
  logic [2:0] warm_v_code_ff;
  logic [1:0] warm_i_code_ff;
  logic [1:0] cool_i_code_ff;
  logic [7:0] nxt_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign temp_hit = (host_addr == tzc_pkg::TEMP_CTRL_ADDR);
  assign zone_hit = (host_addr == tzc_pkg::ZONE_CTRL_ADDR);

  // Host writes that reach a register; either reset request in the same
  // cycle wins, so a write racing a watchdog expiry is dropped, not merged
  assign temp_write = host_wr && temp_hit && !reg_reset && !watchdog_expire;
  assign zone_write = host_wr && zone_hit && !reg_reset && !watchdog_expire;

  //////////////////////////////////////////////////////////////////////////////
  // Temperature control register, one process per field
  // Fields live in their own flip-flops so each keeps its own reset sources

  // regulation code, restored by watchdog and register reset
  // The default code selects the highest regulation threshold
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      die_reg_code_ff <= tzc_pkg::TEMP_CTRL_RST[tzc_pkg::DIE_REG_LSB +: 2];
    end else if (reg_reset || watchdog_expire) begin
      die_reg_code_ff <= tzc_pkg::TEMP_CTRL_RST[tzc_pkg::DIE_REG_LSB +: 2];
    end else if (temp_write) begin
      die_reg_code_ff <= host_wdata[tzc_pkg::DIE_REG_LSB +: 2];
    end
  end

  // shutdown code, restored by watchdog and register reset
  // The default code selects the highest shutdown threshold
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      die_shut_code_ff <= tzc_pkg::TEMP_CTRL_RST[tzc_pkg::DIE_SHUT_LSB +: 2];
    end else if (reg_reset || watchdog_expire) begin
      die_shut_code_ff <= tzc_pkg::TEMP_CTRL_RST[tzc_pkg::DIE_SHUT_LSB +: 2];
    end else if (temp_write) begin
      die_shut_code_ff <= host_wdata[tzc_pkg::DIE_SHUT_LSB +: 2];
    end
  end

  // enable bits and the backup bit; watchdog leaves them alone
  // so a host that set a pull-down keeps it across a firmware stall
  for (genvar b = 0; b < 4; b++) begin : g_temp_low
    logic bit_ff;
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        bit_ff <= tzc_pkg::TEMP_CTRL_RST[b];
      end else if (reg_reset) begin
        bit_ff <= tzc_pkg::TEMP_CTRL_RST[b];
      end else if (watchdog_expire && !tzc_pkg::TEMP_CTRL_WD_KEEP[b]) begin
        bit_ff <= tzc_pkg::TEMP_CTRL_RST[b];
      end else if (temp_write) begin
        bit_ff <= host_wdata[b];
      end
    end
    // Gather the bit into the low nibble
    assign temp_low_bits[b] = bit_ff;
  end

  // assemble the temperature control register from its fields
  // Fields are placed by the package positions, so a move is made in one place
  always_comb begin
    temperature_control_ff = 8'h00;
    temperature_control_ff[tzc_pkg::DIE_REG_LSB +: 2] = die_reg_code_ff;
    temperature_control_ff[tzc_pkg::DIE_SHUT_LSB +: 2] = die_shut_code_ff;
    temperature_control_ff[tzc_pkg::BKUP_FET_BIT +: 4] = temp_low_bits;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Temperature-zone register, one process per field
  // A watchdog expiry returns every zone field to its default

  // warm voltage code
  // The default code lowers the voltage target by a mid-range step
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      warm_v_code_ff <= tzc_pkg::ZONE_CTRL_RST[tzc_pkg::WARM_V_LSB +: 3];
    end else if (reg_reset || watchdog_expire) begin
      warm_v_code_ff <= tzc_pkg::ZONE_CTRL_RST[tzc_pkg::WARM_V_LSB +: 3];
    end else if (zone_write) begin
      warm_v_code_ff <= host_wdata[tzc_pkg::WARM_V_LSB +: 3];
    end
  end

  // warm current code, watchdog and register reset
  // Code 0 is not listed; the decode treats it as a suspend
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      warm_i_code_ff <= tzc_pkg::ZONE_CTRL_RST[tzc_pkg::WARM_I_LSB +: 2];
    end else if (reg_reset || watchdog_expire) begin
      warm_i_code_ff <= tzc_pkg::ZONE_CTRL_RST[tzc_pkg::WARM_I_LSB +: 2];
    end else if (zone_write) begin
      warm_i_code_ff <= host_wdata[tzc_pkg::WARM_I_LSB +: 2];
    end
  end

  // cool current code
  // The default code charges at a fifth of the current target
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cool_i_code_ff <= tzc_pkg::ZONE_CTRL_RST[tzc_pkg::COOL_I_LSB +: 2];
    end else if (reg_reset || watchdog_expire) begin
      cool_i_code_ff <= tzc_pkg::ZONE_CTRL_RST[tzc_pkg::COOL_I_LSB +: 2];
    end else if (zone_write) begin
      cool_i_code_ff <= host_wdata[tzc_pkg::COOL_I_LSB +: 2];
    end
  end

  // reserved bit is not stored, so writes to it cannot stick
  always_comb begin
    temp_zone_charge_control_ff = 8'h00;
    temp_zone_charge_control_ff[tzc_pkg::WARM_V_LSB +: 3] = warm_v_code_ff;
    temp_zone_charge_control_ff[tzc_pkg::WARM_I_LSB +: 2] = warm_i_code_ff;
    temp_zone_charge_control_ff[tzc_pkg::COOL_I_LSB +: 2] = cool_i_code_ff;
    temp_zone_charge_control_ff[tzc_pkg::ZONE_RSVD_BIT] = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data mux, unmapped offsets read as zero
  // A read and a write in one cycle return the value before the write
  always_comb begin
    if (temp_hit) begin
      nxt_rdata = temperature_control_ff;
    end else if (zone_hit) begin
      nxt_rdata = temp_zone_charge_control_ff;
    end else begin
      nxt_rdata = tzc_pkg::UNMAPPED_RDATA;
    end
  end

  // Read answer one cycle after the strobe
  // Read data holds between reads; only the valid pulse marks a fresh answer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_rdata_ff <= tzc_pkg::UNMAPPED_RDATA;
      host_rvalid_ff <= 1'b0;
    end else begin
      host_rvalid_ff <= host_rd;
      if (host_rd) begin
        host_rdata_ff <= nxt_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pull-down and backup enables taken straight from the stored bits
  // bus input pull-down
  assign bus_input_pulldown_enable = temp_low_bits[tzc_pkg::BUS_PD_BIT];
  assign first_sense_pulldown_enable = temp_low_bits[tzc_pkg::FIRST_PD_BIT];
  assign second_sense_pulldown_enable = temp_low_bits[tzc_pkg::SECOND_PD_BIT];
  // Backup bit is plain storage, passed out unchanged
  assign backup_input_fet_on = temp_low_bits[tzc_pkg::BKUP_FET_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Field decode into thresholds and charge scaling
  // field decode
  tzc_setting_decode tzc_setting_decode_inst (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .die_regulation_threshold(die_reg_code_ff),
    .die_shutdown_threshold(die_shut_code_ff),
    .warm_zone_voltage_setting(warm_v_code_ff),
    .warm_zone_current_setting(warm_i_code_ff),
    .cool_zone_current_setting(cool_i_code_ff),
    .die_reg_temp_ff(die_reg_temp_ff),
    .die_shut_temp_ff(die_shut_temp_ff),
    .warm_voltage_drop_ff(warm_voltage_drop_ff),
    .warm_voltage_suspend_ff(warm_voltage_suspend_ff),
    .warm_current_pct_ff(warm_current_pct_ff),
    .cool_current_pct_ff(cool_current_pct_ff)
  );

endmodule : tzc_regs

/* File: sim/tzc_regs_checker.sv */
// Port-level assertions for the register bank
`timescale 1ns/1ps
module tzc_regs_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic reg_reset,
  input wire logic watchdog_expire,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic host_rd,
  input wire logic [7:0] host_rdata_ff,
  input wire logic host_rvalid_ff,
  input wire logic [7:0] temperature_control_ff,
  input wire logic [7:0] temp_zone_charge_control_ff,
  input wire logic bus_input_pulldown_enable,
  input wire logic [7:0] die_reg_temp_ff,
  input wire logic [6:0] cool_current_pct_ff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Register reset and watchdog loading
  reg_defaults_a: assert property (reg_reset |=> temperature_control_ff == 8'hc0 &&
    temp_zone_charge_control_ff == 8'h7a) else $error("register reset value wrong");
  rsvd_zero_a: assert property (!temp_zone_charge_control_ff[0])
    else $error("reserved bit set");
  wd_keep_a: assert property (watchdog_expire && !reg_reset |=>
    temperature_control_ff == {4'hc, $past(temperature_control_ff[3:0])}) else $error("wd temp");
  wd_zone_a: assert property (watchdog_expire && !reg_reset |=>
    temp_zone_charge_control_ff == 8'h7a) else $error("wd zone");
  // Host port behaviour and decode
  bus_pd_a: assert property (bus_input_pulldown_enable == temperature_control_ff[3])
    else $error("bus pull-down mismatch");
  wr_temp_a: assert property (host_wr && host_addr == 8'h16 && !reg_reset && !watchdog_expire
    |=> temperature_control_ff == $past(host_wdata)) else $error("write lost");
  rd_zone_a: assert property (host_rd && host_addr == 8'h17 |=> host_rvalid_ff &&
    host_rdata_ff == $past(temp_zone_charge_control_ff)) else $error("read wrong");
  die_low_a: assert property (temperature_control_ff[7:6] == 2'h0 |=>
    die_reg_temp_ff == 8'h3c) else $error("die threshold decode");
  cool_stop_a: assert property (temp_zone_charge_control_ff[2:1] == 2'h0 |=>
    cool_current_pct_ff == 7'h00) else $error("cool suspend decode");
  cover property (reg_reset);
  cover property (watchdog_expire && host_wr);
  cover property (host_rvalid_ff);
endmodule : tzc_regs_checker
bind tzc_regs tzc_regs_checker tzc_regs_checker_inst (.ref_clk(ref_clk), .arst_n(arst_n),
  .reg_reset(reg_reset), .watchdog_expire(watchdog_expire), .host_addr(host_addr),
  .host_wr(host_wr), .host_wdata(host_wdata), .host_rd(host_rd), .host_rdata_ff(host_rdata_ff),
  .host_rvalid_ff(host_rvalid_ff), .temperature_control_ff(temperature_control_ff),
  .temp_zone_charge_control_ff(temp_zone_charge_control_ff),
  .bus_input_pulldown_enable(bus_input_pulldown_enable), .die_reg_temp_ff(die_reg_temp_ff),
  .cool_current_pct_ff(cool_current_pct_ff));

/* File: sim/tzc_host_model.sv */
// Host processor model for the register port
`timescale 1ns/1ps
module tzc_host_model (
  input wire logic ref_clk,
  output logic [7:0] host_addr,
  output logic host_wr,
  output logic [7:0] host_wdata,
  output logic host_rd,
  input wire logic [7:0] host_rdata_ff,
  input wire logic host_rvalid_ff
);
  // Strobes idle low from time zero
  initial begin
    host_addr = 8'h00;
    host_wr = 1'b0;
    host_wdata = 8'h00;
    host_rd = 1'b0;
  end
  // One write; idle buses then carry inverted values, never stale ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge ref_clk);
    host_wr <= 1'b0;
    host_addr <= ~a;
    host_wdata <= ~d;
  endtask : wr
  // One read; answer taken in the cycle it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge ref_clk);
    host_rd <= 1'b0;
    host_addr <= ~a;
    #1;
    d = host_rdata_ff;
    v = host_rvalid_ff;
  endtask : rd
endmodule : tzc_host_model

/* File: sim/tzc_regs_bench.sv */
// Self-checking bench for the thermal and temperature-zone register bank
`timescale 1ns/1ps
module tzc_regs_bench;
  logic ref_clk, arst_n, reg_reset, watchdog_expire, host_wr, host_rd, host_rvalid_ff, rv;
  logic [7:0] host_addr, host_wdata, host_rdata_ff, temperature_control_ff, rdat;
  logic [7:0] temp_zone_charge_control_ff, die_reg_temp_ff, die_shut_temp_ff;
  logic bus_input_pulldown_enable, first_sense_pulldown_enable, second_sense_pulldown_enable;
  logic backup_input_fet_on, warm_voltage_suspend_ff;
  logic [9:0] warm_voltage_drop_ff;
  logic [6:0] warm_current_pct_ff, cool_current_pct_ff;
  int n_fail, compares;
  tzc_regs tzc_regs_inst (.*);
  tzc_host_model tzc_host_model_inst (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  // Values after reset, directly and over the port
  task automatic t_reset;
    chk("temp", temperature_control_ff, 8'hc0);
    chk("zone", temp_zone_charge_control_ff, 8'h7a);
    tzc_host_model_inst.rd(8'h16, rdat, rv);
    chk("rd16", {rv, rdat}, 9'h1c0);
    tzc_host_model_inst.rd(8'h17, rdat, rv);
    chk("rd17", {rv, rdat}, 9'h17a);
    $display("reset test done");
  endtask : t_reset
  // Every threshold code with one pull-down or the backup bit at a time
  task automatic t_temp;
    logic [7:0] rt [4] = '{8'h3c, 8'h50, 8'h64, 8'h78};
    logic [7:0] st [4] = '{8'h96, 8'h82, 8'h78, 8'h55};
    for (int i = 0; i < 4; i++) begin
      tzc_host_model_inst.wr(8'h16, {i[1:0], i[1:0], 4'h1 << i});
      tick(1);
      chk("bus pd", bus_input_pulldown_enable, i == 3);
      chk("pd1", first_sense_pulldown_enable, i == 2);
      chk("pd2", second_sense_pulldown_enable, i == 1);
      chk("bkup", backup_input_fet_on, i == 0);
      chk("dreg", die_reg_temp_ff, rt[i]);
      chk("dshut", die_shut_temp_ff, st[i]);
    end
    $display("temp test done");
  endtask : t_temp
  // Every zone code, reserved bit written as one
  task automatic t_zone;
    logic [9:0] dr [8] = '{10'h000, 10'h320, 10'h258, 10'h190, 10'h12c, 10'h0c8, 10'h064,
      10'h000};
    logic [6:0] pc [4] = '{7'h00, 7'h14, 7'h28, 7'h64};
    for (int i = 0; i < 8; i++) begin
      tzc_host_model_inst.wr(8'h17, {i[2:0], i[1:0], i[1:0], 1'b1});
      tick(1);
      chk("rsvd", temp_zone_charge_control_ff[0], 1'b0);
      if (i > 0) chk("drop", warm_voltage_drop_ff, dr[i]);
      chk("susp", warm_voltage_suspend_ff, i == 0);
      chk("warm i", warm_current_pct_ff, pc[i % 4]);
      chk("cool i", cool_current_pct_ff, pc[i % 4]);
    end
    $display("zone test done");
  endtask : t_zone
  // Watchdog beats a write, register reset, unmapped place
  task automatic t_wd;
    tzc_host_model_inst.wr(8'h16, 8'h3f);
    tzc_host_model_inst.wr(8'h17, 8'h00);
    fork
      tzc_host_model_inst.wr(8'h16, 8'h05);
      begin
        @(posedge ref_clk);
        watchdog_expire <= 1'b1;
        @(posedge ref_clk);
        watchdog_expire <= 1'b0;
      end
    join
    tick(0);
    chk("wd temp", temperature_control_ff, 8'hcf);
    chk("wd zone", temp_zone_charge_control_ff, 8'h7a);
    @(posedge ref_clk);
    reg_reset <= 1'b1;
    @(posedge ref_clk);
    reg_reset <= 1'b0;
    tick(0);
    chk("rr temp", temperature_control_ff, 8'hc0);
    tzc_host_model_inst.wr(8'h18, 8'hff);
    tzc_host_model_inst.rd(8'h18, rdat, rv);
    chk("rd18", {rv, rdat}, 9'h100);
    chk("temp kept", temperature_control_ff, 8'hc0);
    $display("watchdog test done");
  endtask : t_wd
  initial begin
    arst_n = 1'b0;
    reg_reset = 1'b0;
    watchdog_expire = 1'b0;
    n_fail = 0;
    compares = 0;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    tick(1);
    t_reset();
    t_temp();
    t_zone();
    t_wd();
    stop_test();
  end
  // Hang guard, far beyond the roughly 60 cycles needed
  initial begin
    #20000;
    n_fail++;
    $display("ERROR run did not finish");
    stop_test();
  end
endmodule : tzc_regs_bench
